// ===== tsf_pkg.sv
package tsf_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TX_FIFO_FLAG_OFF   = 8'h00; // flag register; index bits read-only, overflow bit write one clears
    localparam logic [7:0] TX_BYTE_COUNT_OFF  = 8'h04; // byte count, write adds a set
    localparam logic [7:0] TX_CONTROL_OFF     = 8'h08; // marker / mode controls
    localparam logic [7:0] INT_STATUS_OFF     = 8'h0C; // sticky events, write one clears
    localparam logic [7:0] INT_MASK_OFF       = 8'h10; // interrupt enables

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int IDX_HI_BIT   = 7;  // upper index flag
    localparam int IDX_LO_BIT   = 6;  // lower index flag
    localparam int OVF_BIT      = 0;  // overflow flag in flag register
    localparam int CTL_REV_BIT  = 0;  // reverse read pointer control
    localparam int CTL_ADV_BIT  = 1;  // advance read marker control
    localparam int CTL_ATM_BIT  = 2;  // automatic transmit management enable
    localparam int CTL_ISO_BIT  = 3;  // isochronous endpoint
    localparam int EV_OVF_BIT   = 0;  // overflow event
    localparam int EV_DISC_BIT  = 1;  // set discarded event

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] IDX_RESET  = 2'h0;
    localparam logic [3:0] CTL_RESET  = 4'h4; // automatic management on by default
    localparam logic [1:0] EV_RESET   = 2'h0;

    // ------------------------------------------------------------------
    // AXI response codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== tsf_index_flags.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// two-bit set index tracker
// ----------------------------------------------------------------------
module tsf_index_flags (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       add_set,     // firmware wrote the byte count
    input  wire logic       drop_now,    // marker advance, applied at once
    input  wire logic       drop_defer,  // marker advance, held until frame start on iso, else applied at once
    input  wire logic       sof,         // start of frame from the interface unit
    input  wire logic       iso_mode,    // isochronous endpoint
    output logic [1:0]      idx_q,       // index flags
    output logic            ovf_pulse    // write with both sets present and no drop
);

    logic [1:0] idx_d;         // next index flags
    logic       pend_q;        // deferred drop waiting for frame start
    logic       drop_eff;      // drop applied this cycle

    // usb-side drops on iso endpoints wait for the frame start
    assign drop_eff = drop_now | (iso_mode ? (pend_q & sof) : drop_defer);

    // ------------------------------------------------------------------
    // pending deferred drop
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else if (iso_mode && drop_defer) begin
            pend_q <= 1'b1;              // new event wins over consumption
        end else if (sof || !iso_mode) begin
            pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // next state: add and drop in the same cycle cancel in count terms, except from empty, where only the add counts
    // ------------------------------------------------------------------
    always_comb begin
        idx_d = idx_q;
        if (add_set && !drop_eff) begin
            case (idx_q)
                2'h0:    idx_d = 2'h1;
                default: idx_d = 2'h3;
            endcase
        end else if (drop_eff && !add_set) begin
            case (idx_q)
                2'h3:    idx_d = 2'h2;   // one set stays
                default: idx_d = 2'h0;
            endcase
        end else if (drop_eff && add_set) begin
            idx_d = (idx_q == 2'h0) ? 2'h1 : idx_q; // empty: only the add counts
        end
    end

    assign ovf_pulse = add_set && !drop_eff && (idx_q == 2'h3);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idx_q <= tsf_pkg::IDX_RESET;
        end else begin
            idx_q <= idx_d;
        end
    end

endmodule

// ===== tsf_top.sv
// Behaviour
// - two read-only index bits at 7:6
// - byte count write adds a set
// - marker advance discards the oldest set
// - manual and non-iso automatic advance clear at once; iso automatic waits for frame start
// - add: 00-01, 01/10-11, 11 stays, overflow
// - drop: 01/10-00, 11-10, 00 stays; reverse none
// - advance control self-clears after marker move
// - automatic mode follows handshake, disables manual controls
`timescale 1ns/100ps
module tsf_top (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // function interface unit, same clock
    input  wire logic        tx_done,     // one-cycle pulse: transmit handshake finished
    input  wire logic        tx_acked,    // handshake result: ack when high, nak when low
    input  wire logic        sof,         // start of frame pulse
    output logic             rd_ptr_reverse, // pulse: reverse read pointer
    output logic             rd_mark_advance,// pulse: advance read marker
    output logic             irq
);

    // ------------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------------
    logic [7:0]  aw_addr_q;    // captured write address
    logic        aw_full_q;    // address held
    logic [31:0] w_data_q;     // captured write data
    logic [3:0]  w_strb_q;     // captured strobes
    logic        w_full_q;     // data held
    logic        wr_fire;      // both halves present, no response pending

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign wr_fire       = aw_full_q && w_full_q && !s_axi_bvalid;

    // address and data are taken in either order and joined here
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // decode of the joined write
    // ------------------------------------------------------------------
    logic [7:0] wr_word;       // word-aligned write address
    logic       wr_hit;        // address is mapped
    logic       wr_lane0;      // low byte enabled
    assign wr_word  = {aw_addr_q[7:2], 2'b00};
    assign wr_lane0 = w_strb_q[0];
    assign wr_hit   = (wr_word == tsf_pkg::TX_FIFO_FLAG_OFF) ||
                      (wr_word == tsf_pkg::TX_BYTE_COUNT_OFF) ||
                      (wr_word == tsf_pkg::TX_CONTROL_OFF) ||
                      (wr_word == tsf_pkg::INT_STATUS_OFF) ||
                      (wr_word == tsf_pkg::INT_MASK_OFF);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tsf_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? tsf_pkg::RESP_OKAY : tsf_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control register and strobes
    // ------------------------------------------------------------------
    logic [3:0] ctl_q;         // iso, auto, advance, reverse
    logic       cnt_wr;        // byte count written
    logic       ctl_wr;        // control written
    logic       auto_en;       // automatic transmit management
    logic       man_adv;       // manual advance takes effect
    logic       man_rev;       // manual reverse takes effect
    logic       auto_adv;      // automatic advance from handshake
    logic       auto_rev;      // automatic reverse from handshake

    assign cnt_wr  = wr_fire && wr_lane0 && (wr_word == tsf_pkg::TX_BYTE_COUNT_OFF);
    assign ctl_wr  = wr_fire && wr_lane0 && (wr_word == tsf_pkg::TX_CONTROL_OFF);
    assign auto_en = ctl_q[tsf_pkg::CTL_ATM_BIT];

    // manual controls act only alone and with automatic mode off
    assign man_adv = !auto_en && ctl_q[tsf_pkg::CTL_ADV_BIT] && !ctl_q[tsf_pkg::CTL_REV_BIT];
    assign man_rev = !auto_en && ctl_q[tsf_pkg::CTL_REV_BIT] && !ctl_q[tsf_pkg::CTL_ADV_BIT];

    // ack or iso advances the marker, non-iso nak reverses the pointer
    assign auto_adv = auto_en && tx_done && (tx_acked || ctl_q[tsf_pkg::CTL_ISO_BIT]);
    assign auto_rev = auto_en && tx_done && !tx_acked && !ctl_q[tsf_pkg::CTL_ISO_BIT];

    assign rd_mark_advance = man_adv || auto_adv;
    assign rd_ptr_reverse  = man_rev || auto_rev;

    // a contested both-set write stays put; it is cleared by software
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= tsf_pkg::CTL_RESET;
        end else if (ctl_wr) begin
            ctl_q <= w_data_q[3:0];
        end else begin
            if (man_adv) begin
                ctl_q[tsf_pkg::CTL_ADV_BIT] <= 1'b0;
            end
            if (man_rev) begin
                ctl_q[tsf_pkg::CTL_REV_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // index flags
    // ------------------------------------------------------------------
    logic [1:0] idx_flags;     // set index flags
    logic       ovf_hit;       // overflow event
    logic       drop_now;      // firmware-caused drop
    logic       drop_usb;      // usb-caused drop

    // reverse events never reach the tracker
    assign drop_now = man_adv;
    assign drop_usb = auto_adv;

    tsf_index_flags u_idx (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .add_set    (cnt_wr),
        .drop_now   (drop_now),
        .drop_defer (drop_usb),
        .sof        (sof),
        .iso_mode   (ctl_q[tsf_pkg::CTL_ISO_BIT]),
        .idx_q      (idx_flags),
        .ovf_pulse  (ovf_hit)
    );

    // ------------------------------------------------------------------
    // overflow flag and interrupts
    // ------------------------------------------------------------------
    logic       ovf_q;         // overflow flag, cleared by writing one
    logic [1:0] ev_q;          // sticky events
    logic [1:0] mask_q;        // interrupt enables
    logic [1:0] ev_set;        // events this cycle
    logic       st_wr;         // status written

    assign ev_set = {rd_mark_advance, ovf_hit};
    assign st_wr  = wr_fire && wr_lane0 && (wr_word == tsf_pkg::INT_STATUS_OFF);

    // set wins over a simultaneous clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovf_q <= 1'b0;
        end else if (ovf_hit) begin
            ovf_q <= 1'b1;
        end else if (wr_fire && wr_lane0 && (wr_word == tsf_pkg::TX_FIFO_FLAG_OFF) &&
                     w_data_q[tsf_pkg::OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ev_q <= tsf_pkg::EV_RESET;
        end else begin
            ev_q <= ev_set | (ev_q & ~(st_wr ? w_data_q[1:0] : 2'b00));
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= tsf_pkg::EV_RESET;
        end else if (wr_fire && wr_lane0 && (wr_word == tsf_pkg::INT_MASK_OFF)) begin
            mask_q <= w_data_q[1:0];
        end
    end

    assign irq = |(ev_q & mask_q);

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic [7:0]  rd_word;      // word-aligned read address
    logic [7:0]  flag_byte;    // flag register image
    assign rd_word   = {s_axi_araddr[7:2], 2'b00};
    assign flag_byte = {idx_flags, 5'b00000, ovf_q};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= tsf_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tsf_pkg::RESP_OKAY;
            case (rd_word)
                tsf_pkg::TX_FIFO_FLAG_OFF: s_axi_rdata <= {24'h000000, flag_byte};
                tsf_pkg::TX_BYTE_COUNT_OFF: s_axi_rdata <= 32'h0000_0000;
                tsf_pkg::TX_CONTROL_OFF:   s_axi_rdata <= {28'h0000000, ctl_q};
                tsf_pkg::INT_STATUS_OFF:   s_axi_rdata <= {30'h0, ev_q};
                tsf_pkg::INT_MASK_OFF:     s_axi_rdata <= {30'h0, mask_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= tsf_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== tsf_fiu_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// interface unit stand-in: transmit handshakes and frame starts
// ------------------------------------------------------------------
module tsf_fiu_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       hs_req,    // bench asks for one handshake
    input  wire logic       hs_ack,    // result to report
    input  wire logic [3:0] hs_delay,  // packet length, prompt or slow
    input  wire logic       frame_req, // bench asks for a frame start
    output logic            tx_done,   // one-cycle end of handshake
    output logic            tx_acked,  // valid only with tx_done
    output logic            sof        // one-cycle frame start
);
    logic [3:0] wait_q; // cycles left in flight
    logic       busy_q; // handshake in flight
    // the result line toggles between pulses so a stale value is never trusted
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {tx_done, tx_acked, sof, busy_q, wait_q} <= '0;
        end else begin
            sof <= frame_req;
            tx_done <= busy_q && wait_q == 4'h0;
            tx_acked <= (busy_q && wait_q == 4'h0) ? hs_ack : ~tx_acked;
            if (hs_req) begin
                busy_q <= 1'b1;
                wait_q <= hs_delay;
            end else if (busy_q) begin
                busy_q <= wait_q != 4'h0;
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule

// ===== tsf_top_properties.sv
`timescale 1ns/100ps
module tsf_top_properties (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        tx_done,
    input wire logic        tx_acked,
    input wire logic        rd_ptr_reverse,
    input wire logic        rd_mark_advance,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // one domain; reset silences every check
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // requests taken at this edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rd_taken |-> ##1 s_axi_rvalid)
        else $error("read response late");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_irq_clears: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("interrupt fell without a write");
    a_one_action: assert property (!(rd_mark_advance && rd_ptr_reverse))
        else $error("advance and reverse together");
    a_reverse_cause: assert property (rd_ptr_reverse |-> (tx_done && !tx_acked)
        || ($past(tx_done) && !$past(tx_acked)) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("reverse without cause");
    // a manual advance is one pulse: the control bit must clear behind it
    a_advance_pulses: assert property (rd_mark_advance && !tx_done |=> !rd_mark_advance)
        else $error("advance control did not clear");
    // without a handshake only a firmware control write may advance the marker
    a_advance_cause: assert property (rd_mark_advance |-> tx_done || s_axi_bvalid)
        else $error("advance without cause");
endmodule
bind tsf_top tsf_top_properties tsf_top_properties_i (.*);

// ===== tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
    // ------------------------------------------------------------
    // signals; both ready lines stay high, the master always accepts
    // ------------------------------------------------------------
    logic        ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, hs_req, hs_ack, frame_req, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_done, tx_acked, sof;
    logic        rd_ptr_reverse, rd_mark_advance, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd; // rd: last word read
    logic [3:0]  s_axi_wstrb, hs_delay;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          num_errors, total_checks, adv_n, rev_n, cyc;
    localparam logic [7:0] FLG = tsf_pkg::TX_FIFO_FLAG_OFF, CNT = tsf_pkg::TX_BYTE_COUNT_OFF;
    localparam logic [7:0] CTL = tsf_pkg::TX_CONTROL_OFF, STS = tsf_pkg::INT_STATUS_OFF;
    localparam logic [7:0] MSK = tsf_pkg::INT_MASK_OFF;
    localparam logic [1:0] ERR = tsf_pkg::RESP_SLVERR;
    tsf_top tsf_top_i (.*);
    tsf_fiu_model tsf_fiu_model_i (.*);
    always #50 ref_clk = ~ref_clk;
    // pulse counters and hang guard
    always @(posedge ref_clk) begin
        adv_n += rd_mark_advance;
        rev_n += rd_ptr_reverse;
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // handshakes are judged at mid-cycle, released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic aw_f, w_f, b_f;
        b_f = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b_f) begin
            @(negedge ref_clk);
            aw_f = s_axi_awvalid && s_axi_awready;
            w_f = s_axi_wvalid && s_axi_wready;
            b_f = s_axi_bvalid;
            if (b_f) `CHK(s_axi_bresp, er)
            @(posedge ref_clk);
            if (aw_f) s_axi_awvalid <= 1'b0;
            if (w_f) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rdw(input logic [7:0] a, input logic [1:0] er = 2'h0);
        logic ar_f, r_f;
        r_f = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_f) begin
            @(negedge ref_clk);
            ar_f = s_axi_arvalid && s_axi_arready;
            r_f = s_axi_rvalid;
            rd = s_axi_rdata;
            if (r_f) `CHK(s_axi_rresp, er)
            @(posedge ref_clk);
            if (ar_f) s_axi_arvalid <= 1'b0;
        end
    endtask
    // index flags and overflow bit of the flag register
    task automatic flg(input logic [1:0] ix, input logic ov);
        rdw(FLG);
        `CHK(rd & 32'hC1, {24'h0, ix, 5'h0, ov})
    endtask
    task automatic hs(input logic ack, input logic [3:0] dly);
        hs_req <= 1'b1;
        hs_ack <= ack;
        hs_delay <= dly;
        @(posedge ref_clk);
        hs_req <= 1'b0;
        do @(posedge ref_clk); while (tx_done !== 1'b1);
    endtask
    // four edges: sof pulse, then the deferred drop lands
    task automatic frame();
        frame_req <= 1'b1;
        @(posedge ref_clk);
        frame_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdw(CTL);
        `CHK(rd, {28'h0, tsf_pkg::CTL_RESET})
        flg(2'h0, 1'b0);
        rdw(8'h14, ERR);
        `CHK(rd, 32'h0)
        wr(8'h14, 32'h1, ERR);
        $display("test reset done");
    endtask
    task automatic t_add();
        wr(MSK, 32'h1);
        wr(CNT, 32'h0);
        flg(2'h1, 1'b0);
        wr(CNT, 32'h0);
        flg(2'h3, 1'b0);
        `CHK(irq, 1'b0)
        wr(CNT, 32'h0);
        flg(2'h3, 1'b1);
        `CHK(irq, 1'b1)
        wr(FLG, 32'hC1);
        flg(2'h3, 1'b0);
        wr(MSK, 32'h0);
        `CHK(irq, 1'b0)
        wr(MSK, 32'h1);
        wr(STS, 32'h1);
        `CHK(irq, 1'b0)
        // byte 0 disabled: the count write must be ignored, no overflow
        s_axi_wstrb <= 4'hE;
        wr(CNT, 32'h0);
        s_axi_wstrb <= 4'hF;
        flg(2'h3, 1'b0);
        $display("test add done");
    endtask
    task automatic t_manual();
        int a0, r0;
        a0 = adv_n;
        r0 = rev_n;
        wr(CTL, 32'h2);
        flg(2'h2, 1'b0);
        rdw(CTL);
        `CHK(rd, 32'h0)
        wr(CNT, 32'h0);
        flg(2'h3, 1'b0);
        wr(CTL, 32'h2);
        wr(CTL, 32'h2);
        flg(2'h0, 1'b0);
        wr(CTL, 32'h2);
        flg(2'h0, 1'b0);
        `CHK(adv_n, a0 + 4)
        rdw(STS);
        `CHK(rd, 32'h2)
        wr(MSK, 32'h2);
        `CHK(irq, 1'b1)
        wr(STS, 32'h2);
        `CHK(irq, 1'b0)
        wr(CNT, 32'h0);
        // both controls together: neither acts, both stay set
        wr(CTL, 32'h3);
        flg(2'h1, 1'b0);
        rdw(CTL);
        `CHK(rd, 32'h3)
        wr(CTL, 32'h1);
        flg(2'h1, 1'b0);
        `CHK(rev_n, r0 + 1)
        $display("test manual done");
    endtask
    task automatic t_auto();
        int a0, r0;
        wr(CTL, 32'h4);
        a0 = adv_n;
        r0 = rev_n;
        hs(1'b1, 4'h0);
        flg(2'h0, 1'b0);
        wr(CNT, 32'h0);
        hs(1'b0, 4'h6);
        flg(2'h1, 1'b0);
        `CHK(rev_n, r0 + 1)
        wr(CTL, 32'h6);
        flg(2'h1, 1'b0);
        `CHK(adv_n, a0 + 1)
        $display("test auto done");
    endtask
    task automatic t_iso();
        wr(CTL, 32'hC);
        hs(1'b0, 4'h2);
        flg(2'h1, 1'b0);
        frame();
        flg(2'h0, 1'b0);
        wr(CNT, 32'h0);
        wr(CNT, 32'h0);
        wr(CTL, 32'hA);
        flg(2'h2, 1'b0);
        $display("test iso done");
    endtask
    initial begin
        {ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hs_req} = '0;
        {hs_ack, frame_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata, hs_delay} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_add();
        t_manual();
        t_auto();
        t_iso();
        tally_and_finish();
    end
endmodule
